// >>> logic/supply_seq_pkg.sv
/*
  Constants, enums and structs for the supply enable sequencer.
  Assumes a 10 MHz core clock and a 32-bit AXI4-Lite register bus.
*/
`default_nettype none
package supply_seq_pkg;
  // Clock and blanking time
  localparam int CLK_PERIOD_NS = 100;
  localparam int BLANK_TIME_US = 150;
  localparam int BLANK_CYCLES =
    (BLANK_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 11;

  // Register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_GATE   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_BOOST  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0C;

  // Field positions
  localparam int CTRL_HOLD_BIT  = 0;
  localparam int CTRL_BOOST_BIT = 1;
  localparam int GATE_SET_LSB   = 0;
  localparam int GATE_UV_LSB    = 4;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_ENA_BIT   = 4;
  localparam int STAT_SUP_BIT   = 5;
  localparam int STAT_UV_BIT    = 6;
  localparam int STAT_UVEV_BIT  = 7;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Pin input order inside the synchroniser vector
  localparam int PIN_ENA1 = 0;
  localparam int PIN_ENA2 = 1;
  localparam int PIN_ENA3 = 2;
  localparam int PIN_CORE = 3;
  localparam int PIN_BATT = 4;
  localparam int PIN_UV   = 5;
  localparam int PIN_N    = 6;

  typedef enum logic [3:0] {
    ST_OFF   = 4'h1,
    ST_POR   = 4'h2,
    ST_BLANK = 4'h4,
    ST_RUN   = 4'h8
  } power_state_e;

  typedef struct packed {
    logic       core_regulator_hold;
    logic       boost_enable;
    logic [3:0] gate_supply_setpoint;
    logic [2:0] gate_supply_uv_threshold;
    logic [6:0] boost_voltage_target;
  } settings_s;

  localparam settings_s SETTINGS_DEFAULT = '{
    core_regulator_hold:      1'b0,
    boost_enable:             1'b0,
    gate_supply_setpoint:     4'h0,
    gate_supply_uv_threshold: 3'h0,
    boost_voltage_target:     7'h00
  };

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              aw_full;
    logic              w_full;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } axi_state_s;

  typedef struct packed {
    logic [PIN_N-1:0] sync1;
    logic [PIN_N-1:0] sync2;
    power_state_e     state;
    logic [CNT_W-1:0] blank_cnt;
    settings_s        cfg;
    logic             uv_event;
    logic             uv_lock;
    logic             core_regulator_on;
    logic             in_reset;
    logic             booster_on;
    logic             sdo_out;
    logic             sdo_oe;
    axi_state_s       axi;
  } seq_state_s;
endpackage
`default_nettype wire

// >>> logic/supply_enable_sequencer.sv
/*
  Supply enable sequencer: enable pins and a software hold bit move the
  chip between reset and normal mode, supplies are qualified, and the
  gate-drive undervoltage lockout switches the booster off.
  Assumes asynchronous pin inputs, same-clock serial data, AXI4-Lite.
*/
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module supply_enable_sequencer
  import supply_seq_pkg::*;
(
  input  wire logic                internal_rc_clock_aclk_unused_n,
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                enable_input_one,
  input  wire logic                failsafe_or_enable_input_two,
  input  wire logic                enable_input_three,
  input  wire logic                core_supply_ok,
  input  wire logic                battery_supply_ok,
  input  wire logic                gate_drive_supply_low,
  input  wire logic                serial_data_bit,
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  output logic                     core_regulator_on,
  output logic                     chip_in_reset,
  output logic                     booster_enable,
  output logic [3:0]               gate_supply_setpoint,
  output logic [2:0]               gate_supply_uv_threshold,
  output logic [6:0]               boost_voltage_target,
  output logic                     sdo_out,
  output logic                     sdo_oe
);

  seq_state_s r;
  seq_state_s n;

  logic              any_enable;
  logic              supplies_ok;
  logic              uv_raw;
  logic              stay_off;
  logic              wr_fire;
  logic              wr_hit;
  logic [31:0]       rd_word;
  logic              rd_hit;
  logic [31:0]       status_word;

  always_comb begin
    any_enable  = |r.sync2[PIN_ENA3:PIN_ENA1];
    supplies_ok = r.sync2[PIN_CORE] & r.sync2[PIN_BATT];
    uv_raw      = r.sync2[PIN_UV];
    stay_off    = !any_enable && !r.cfg.core_regulator_hold;
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[STAT_STATE_LSB +: 4] = r.state;
    status_word[STAT_ENA_BIT]  = any_enable;
    status_word[STAT_SUP_BIT]  = supplies_ok;
    status_word[STAT_UV_BIT]   = r.uv_lock;
    status_word[STAT_UVEV_BIT] = r.uv_event;
  end

  // Read decode
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    unique case (s_axi_araddr)
      OFS_CTRL: begin
        rd_word[CTRL_HOLD_BIT]  = r.cfg.core_regulator_hold;
        rd_word[CTRL_BOOST_BIT] = r.cfg.boost_enable;
      end
      OFS_GATE: begin
        rd_word[GATE_SET_LSB +: 4] = r.cfg.gate_supply_setpoint;
        rd_word[GATE_UV_LSB +: 3]  = r.cfg.gate_supply_uv_threshold;
      end
      OFS_BOOST: begin
        rd_word[6:0] = r.cfg.boost_voltage_target;
      end
      OFS_STATUS: begin
        rd_word = status_word;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    wr_hit = (r.axi.awaddr == OFS_CTRL) || (r.axi.awaddr == OFS_GATE) ||
             (r.axi.awaddr == OFS_BOOST) || (r.axi.awaddr == OFS_STATUS);
  end

  always_comb begin
    n = r;
    wr_fire = 1'b0;

    // Pin synchronisers
    n.sync1 = {gate_drive_supply_low, battery_supply_ok, core_supply_ok,
               enable_input_three, failsafe_or_enable_input_two,
               enable_input_one};
    n.sync2 = r.sync1;

    // Write channel capture
    if (s_axi_awvalid && r.axi.awready) begin
      n.axi.aw_full = 1'b1;
      n.axi.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.axi.wready) begin
      n.axi.w_full = 1'b1;
      n.axi.wdata  = s_axi_wdata;
      n.axi.wstrb  = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      n.axi.bvalid = 1'b0;
    end
    if (r.axi.aw_full && r.axi.w_full && !r.axi.bvalid) begin
      wr_fire       = 1'b1;
      n.axi.aw_full = 1'b0;
      n.axi.w_full  = 1'b0;
      n.axi.bvalid  = 1'b1;
      n.axi.bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    n.axi.awready = !n.axi.aw_full && !n.axi.bvalid;
    n.axi.wready  = !n.axi.w_full && !n.axi.bvalid;

    // Register writes, low byte carries every field
    if (wr_fire && r.axi.wstrb[0]) begin
      unique case (r.axi.awaddr)
        OFS_CTRL: begin
          n.cfg.core_regulator_hold = r.axi.wdata[CTRL_HOLD_BIT];
          n.cfg.boost_enable        = r.axi.wdata[CTRL_BOOST_BIT];
        end
        OFS_GATE: begin
          n.cfg.gate_supply_setpoint =
            r.axi.wdata[GATE_SET_LSB +: 4];
          n.cfg.gate_supply_uv_threshold =
            r.axi.wdata[GATE_UV_LSB +: 3];
        end
        OFS_BOOST: begin
          n.cfg.boost_voltage_target = r.axi.wdata[6:0];
        end
        OFS_STATUS: begin
          if (r.axi.wdata[STAT_UVEV_BIT]) begin
            n.uv_event = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Read channel
    if (s_axi_rvalid && s_axi_rready) begin
      n.axi.rvalid  = 1'b0;
      n.axi.arready = 1'b1;
    end
    if (s_axi_arvalid && r.axi.arready) begin
      n.axi.arready = 1'b0;
      n.axi.rvalid  = 1'b1;
      n.axi.rdata   = rd_word;
      n.axi.rresp   = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end

    // Power state sequence, all timing on aclk
    unique case (r.state)
      ST_OFF: begin
        if (any_enable) begin
          n.state = ST_POR;
        end
      end
      ST_POR: begin
        if (stay_off) begin
          n.state = ST_OFF;
        end else if (supplies_ok) begin
          n.state     = ST_BLANK;
          n.blank_cnt = '0;
        end
      end
      ST_BLANK: begin
        if (stay_off) begin
          n.state = ST_OFF;
        end else if (!supplies_ok) begin
          n.state = ST_POR;
        end else if (r.blank_cnt == CNT_W'(BLANK_CYCLES - 1)) begin
          n.state = ST_RUN;
        end else begin
          n.blank_cnt = r.blank_cnt + CNT_W'(1);
        end
      end
      ST_RUN: begin
        if (stay_off) begin
          n.state = ST_OFF;
        end else if (!supplies_ok) begin
          n.state = ST_POR;
        end
      end
      default: begin
        n.state = ST_OFF;
      end
    endcase

    n.in_reset = (n.state == ST_OFF) || (n.state == ST_POR);

    // Reset state forces defaults, hold bit included
    if (n.in_reset) begin
      n.cfg = SETTINGS_DEFAULT;
    end

    // Regulator on out of OFF; hold keeps it on with enables low
    n.core_regulator_on = (n.state != ST_OFF);

    // Lockout only after blanking and with nonzero threshold
    n.uv_lock = (r.state == ST_RUN) && uv_raw &&
                (r.cfg.gate_supply_uv_threshold != 3'h0);
    if (n.uv_lock) begin
      n.uv_event = 1'b1;
    end

    n.booster_on = (n.state == ST_RUN) && n.cfg.boost_enable &&
                   !n.uv_lock;

    // Open-drain serial output: drive low or release
    n.sdo_out = 1'b0;
    n.sdo_oe  = !serial_data_bit && !n.in_reset;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r.sync1             <= '0;
      r.sync2             <= '0;
      r.state             <= ST_OFF;
      r.blank_cnt         <= '0;
      r.cfg               <= SETTINGS_DEFAULT;
      r.uv_event          <= 1'b0;
      r.uv_lock           <= 1'b0;
      r.core_regulator_on <= 1'b0;
      r.in_reset          <= 1'b1;
      r.booster_on        <= 1'b0;
      r.sdo_out           <= 1'b0;
      r.sdo_oe            <= 1'b0;
      r.axi.awready       <= 1'b1;
      r.axi.wready        <= 1'b1;
      r.axi.aw_full       <= 1'b0;
      r.axi.w_full        <= 1'b0;
      r.axi.awaddr        <= '0;
      r.axi.wdata         <= 32'h0000_0000;
      r.axi.wstrb         <= 4'h0;
      r.axi.bvalid        <= 1'b0;
      r.axi.bresp         <= RESP_OKAY;
      r.axi.arready       <= 1'b1;
      r.axi.rvalid        <= 1'b0;
      r.axi.rdata         <= 32'h0000_0000;
      r.axi.rresp         <= RESP_OKAY;
    end else begin
      r <= n;
    end
  end

  always_comb begin
    s_axi_awready            = r.axi.awready;
    s_axi_wready             = r.axi.wready;
    s_axi_bvalid             = r.axi.bvalid;
    s_axi_bresp              = r.axi.bresp;
    s_axi_arready            = r.axi.arready;
    s_axi_rvalid             = r.axi.rvalid;
    s_axi_rdata              = r.axi.rdata;
    s_axi_rresp              = r.axi.rresp;
    core_regulator_on        = r.core_regulator_on;
    chip_in_reset            = r.in_reset;
    booster_enable           = r.booster_on;
    gate_supply_setpoint     = r.cfg.gate_supply_setpoint;
    gate_supply_uv_threshold = r.cfg.gate_supply_uv_threshold;
    boost_voltage_target     = r.cfg.boost_voltage_target;
    sdo_out                  = r.sdo_out;
    sdo_oe                   = r.sdo_oe;
  end

endmodule // supply_enable_sequencer
`default_nettype wire

// >>> dv/supply_seq_chk.sv
/*
  Checker for the supply enable sequencer top-level ports.
  Assumes one clock domain, aclk, with synchronous active-low aresetn.
*/
`timescale 1ns/1ps
`default_nettype none
module supply_seq_chk
  import supply_seq_pkg::*;
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       enable_input_one,
  input wire logic       failsafe_or_enable_input_two,
  input wire logic       enable_input_three,
  input wire logic       core_supply_ok,
  input wire logic       battery_supply_ok,
  input wire logic       gate_drive_supply_low,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       core_regulator_on,
  input wire logic       chip_in_reset,
  input wire logic       booster_enable,
  input wire logic [3:0] gate_supply_setpoint,
  input wire logic [2:0] gate_supply_uv_threshold,
  input wire logic [6:0] boost_voltage_target,
  input wire logic       sdo_out,
  input wire logic       sdo_oe
);
  logic        en_any;
  logic [11:0] run_cnt_r;
  assign en_any = enable_input_one | failsafe_or_enable_input_two | enable_input_three;
  // Cycles since leaving reset, saturating
  always_ff @(posedge aclk) begin
    run_cnt_r <= (!aresetn || chip_in_reset) ? 12'h000 : run_cnt_r + {11'h000, ~&run_cnt_r};
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  reg_on_cause_a: assert property ($rose(core_regulator_on) |->
    $past(en_any, 2) || $past(en_any, 3) || $past(en_any, 4) || $past(en_any, 5))
    else $error("regulator on without enable");
  idle_off_a: assert property ((chip_in_reset && !en_any) [*6] |=> !core_regulator_on)
    else $error("regulator left on while idle");
  supply_hold_a: assert property (!(core_supply_ok && battery_supply_ok) [*5] |-> chip_in_reset)
    else $error("out of reset with bad supply");
  reset_defaults_a: assert property (chip_in_reset && $past(chip_in_reset)
    |-> !booster_enable && {gate_supply_setpoint, gate_supply_uv_threshold, boost_voltage_target} == '0)
    else $error("settings not at default in reset");
  uv_lockout_a: assert property ((gate_drive_supply_low && gate_supply_uv_threshold != 0
    && run_cnt_r > BLANK_CYCLES + 2) [*5] |-> !booster_enable)
    else $error("booster on under undervoltage");
  blank_ignore_a: assert property ((en_any && core_supply_ok && battery_supply_ok
    && !chip_in_reset && run_cnt_r > 3 && run_cnt_r < BLANK_CYCLES - 4) [*4] |=> !chip_in_reset)
    else $error("blanking interrupted");
  sdo_low_a: assert property (sdo_oe |-> !sdo_out)
    else $error("serial output driven high");
  sdo_released_a: assert property (chip_in_reset && $past(chip_in_reset) |-> !sdo_oe)
    else $error("serial output driven in reset");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  cover property ($rose(core_regulator_on));
  cover property ($fell(booster_enable) && !chip_in_reset);
  cover property (s_axi_bvalid && s_axi_bready);
endmodule // supply_seq_chk
bind supply_enable_sequencer supply_seq_chk u_supply_seq_chk (.*);
`default_nettype wire

// >>> dv/host_pins.sv
/*
  Host-side pin model: enable pin drivers and the serial output pull-up.
  Assumes the bench commands pin levels on the rising edge of aclk.
*/
`timescale 1ns/1ps
`default_nettype none
module host_pins (
  input  wire logic       aclk,
  input  wire logic [2:0] ena_cmd,
  input  wire logic       sdo_out,
  input  wire logic       sdo_oe,
  output logic [2:0]      ena_pins,
  output logic            sdo_line
);
  initial ena_pins = '0;
  always @(posedge aclk) ena_pins <= ena_cmd;
  // Pull-up supplies the high level
  assign sdo_line = sdo_oe ? sdo_out : 1'h1;
endmodule // host_pins
`default_nettype wire

// >>> dv/test_supply_enable_sequencer.sv
/*
  Self-checking bench for the supply enable sequencer with a register model.
  Assumes the package constants and a 100 ns aclk.
*/
`timescale 1ns/1ps
`default_nettype none
module test_supply_enable_sequencer
  import supply_seq_pkg::*;
;
  logic aclk, aresetn, internal_rc_clock_aclk_unused_n, serial_data_bit;
  logic enable_input_one, failsafe_or_enable_input_two, enable_input_three;
  logic core_supply_ok, battery_supply_ok, gate_drive_supply_low;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb, gate_supply_setpoint;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic core_regulator_on, chip_in_reset, booster_enable, sdo_out, sdo_oe, sdo_line;
  logic [2:0] gate_supply_uv_threshold, ena_cmd, ena_pins;
  logic [6:0] boost_voltage_target;
  int err_total, num_checks, seed, i, m[3];
  int msk[3] = '{32'h0000_0003, 32'h0000_007f, 32'h0000_007f};
  bit live;
  assign {enable_input_three, failsafe_or_enable_input_two, enable_input_one} = ena_pins;
  supply_enable_sequencer u_supply_enable_sequencer (.*);
  host_pins u_host_pins (.*);
  initial begin
    aclk = 0;
    forever #50 aclk = ~aclk;
  end
  task ck(input bit ok);
    num_checks++;
    if (!ok) begin
      err_total++;
      $display("mismatch at %0t: unexpected value", $time);
    end
  endtask
  task results;
    if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wait_lvl(ref logic s, input logic v, input int n);
    repeat (n) if (s !== v) @(posedge aclk);
    ck(s === v);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= '1;
    s_axi_awvalid <= '1;
    s_axi_wvalid <= '1;
    s_axi_bready <= '1;
    fork
      begin
        do @(posedge aclk); while (!s_axi_awready);
        s_axi_awvalid <= '0;
      end
      begin
        do @(posedge aclk); while (!s_axi_wready);
        s_axi_wvalid <= '0;
      end
    join
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= '0;
    ck(s_axi_bresp === RESP_OKAY);
    if (live) m[a[3:2]] = v & msk[a[3:2]];
    @(posedge aclk);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= '1;
    s_axi_rready <= '1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= '0;
    while (!s_axi_rvalid) @(posedge aclk);
    r = s_axi_rdata;
    s_axi_rready <= '0;
    ck(s_axi_rresp === (a > OFS_STATUS ? RESP_SLVERR : RESP_OKAY));
    if (a != OFS_STATUS) ck(r === (a > OFS_STATUS ? 0 : m[a[3:2]]));
    @(posedge aclk);
  endtask
  always @(posedge aclk) serial_data_bit <= 1'($random(seed));
  always @(posedge aclk) if (sdo_oe === 1'h1) ck(sdo_line === 1'h0);
  initial begin
    seed = 32'h0000_e905;
    {aresetn, internal_rc_clock_aclk_unused_n, serial_data_bit, ena_cmd} = '0;
    {core_supply_ok, battery_supply_ok, gate_drive_supply_low} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= '1;
    @(posedge aclk);
    ck(core_regulator_on === 0 && chip_in_reset === 1 && booster_enable === 0);
    ck({gate_supply_setpoint, gate_supply_uv_threshold, boost_voltage_target} === '0);
    wr(OFS_GATE, 32'h0000_0035);
    rd(OFS_GATE, d);
    core_supply_ok <= '1;
    for (i = 0; i < 3; i++) begin
      ena_cmd <= 3'(1 << i);
      wait_lvl(core_regulator_on, 1, 10);
      repeat (8) @(posedge aclk);
      ck(chip_in_reset === 1);
      ena_cmd <= '0;
      wait_lvl(core_regulator_on, 0, 10);
    end
    ena_cmd <= 3'h4;
    battery_supply_ok <= '1;
    wait_lvl(chip_in_reset, 0, 12);
    live = 1;
    for (i = 0; i < 16; i++) begin
      d = {$random(seed)} & 32'h0000_0070 | i;
      wr(OFS_GATE, d);
      repeat (2) @(posedge aclk);
      ck({gate_supply_uv_threshold, gate_supply_setpoint} === d[6:0]);
      rd(OFS_GATE, d);
    end
    wr(OFS_GATE, 32'h0000_0035);
    wr(OFS_BOOST, 32'h0000_007f);
    wr(OFS_CTRL, 32'h0000_0002);
    gate_drive_supply_low <= '1;
    repeat (8) @(posedge aclk);
    ck(booster_enable === 0 && chip_in_reset === 0 && boost_voltage_target === 7'h7f);
    repeat (BLANK_CYCLES) @(posedge aclk);
    rd(OFS_STATUS, d);
    ck(d[3:0] === 4'h8 && d[6] === 1 && booster_enable === 0);
    wr(OFS_GATE, 32'h0000_0005);
    wait_lvl(booster_enable, 1, 10);
    wr(OFS_GATE, 32'h0000_0035);
    wait_lvl(booster_enable, 0, 10);
    gate_drive_supply_low <= '0;
    wait_lvl(booster_enable, 1, 10);
    rd(8'h10, d);
    wr(OFS_CTRL, 32'h0000_0003);
    ena_cmd <= '0;
    repeat (12) @(posedge aclk);
    ck(core_regulator_on === 1 && chip_in_reset === 0);
    wr(OFS_CTRL, 32'h0000_0002);
    wait_lvl(core_regulator_on, 0, 10);
    live = 0;
    m = '{0, 0, 0};
    repeat (2) @(posedge aclk);
    ck(chip_in_reset === 1 && booster_enable === 0 && gate_supply_setpoint === '0);
    rd(OFS_CTRL, d);
    results;
  end
  initial begin
    repeat (5000) @(posedge aclk);
    err_total++;
    $display("mismatch at %0t: timeout", $time);
    results;
  end
endmodule // test_supply_enable_sequencer
`default_nettype wire
